// *** channel_clock_src.sv ***
// Purpose: Stand-in for the channel clocks feeding the output gates
// Assumes: Same domain as ref_clk
// Notes: Alternating pattern so a stuck gate shows at once
`timescale 1ns/10ps
`default_nettype none
module channel_clock_src
(
    // Clock
    input wire logic ref_clk,
    // Channel clocks
    output logic [7:0] clock_in
);
    // One process owns the pattern, so the output has a single driver
    initial
    begin
        clock_in = 8'h55;
        forever @(posedge ref_clk)
            clock_in <= ~clock_in;
    end
endmodule
`default_nettype wire

// *** output_slot.sv ***
// Purpose: Storage for the three registers of one output
// Assumes: Strobes come decoded from the bank on ref_clk
// Notes: Reserved positions are masked on write so they read zero
`timescale 1ns/10ps
`default_nettype none
module output_slot
    import sync_output_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Bank side
    reg_slot_if.slot bus
);

    wire logic [REG_W-1:0] next_sel_delay;
    wire logic [REG_W-1:0] next_state;
    wire logic [REG_W-1:0] next_clk_ctrl;

    assign next_sel_delay = bus.wdata & SEL_DELAY_MASK;
    assign next_state = bus.wdata & STATE_MASK;
    assign next_clk_ctrl = bus.wdata & CLK_CTRL_MASK;

    // Source select resets to the central reference
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            bus.sel_delay <= SEL_DELAY_RESET;
        else if (bus.wr_sel_delay)
            bus.sel_delay <= next_sel_delay;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            bus.state <= STATE_RESET;
        else if (bus.wr_state)
            bus.state <= next_state;
    end

    // Differential format, disabled and powered up after reset
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            bus.clk_ctrl <= CLK_CTRL_RESET;
        else if (bus.wr_clk_ctrl)
            bus.clk_ctrl <= next_clk_ctrl;
    end

endmodule
`default_nettype wire

// *** reg_slot_if.sv ***
// Purpose: Write strobes and stored values of one output's registers
// Assumes: Single clock domain, strobes last one cycle
// Notes: The bank drives strobes, the slot returns stored bytes
`timescale 1ns/10ps
`default_nettype none
interface reg_slot_if;
    logic wr_sel_delay;
    logic wr_state;
    logic wr_clk_ctrl;
    logic [7:0] wdata;
    logic [7:0] sel_delay;
    logic [7:0] state;
    logic [7:0] clk_ctrl;

    modport bank (
        output wr_sel_delay,
        output wr_state,
        output wr_clk_ctrl,
        output wdata,
        input sel_delay,
        input state,
        input clk_ctrl
    );

    modport slot (
        input wr_sel_delay,
        input wr_state,
        input wr_clk_ctrl,
        input wdata,
        output sel_delay,
        output state,
        output clk_ctrl
    );
endinterface
`default_nettype wire

// *** sync_output_pkg.sv ***
// Purpose: Constants for the sync and clock output register bank
// Assumes: Registers are 8 bits wide, one per aligned 32-bit APB word
// Notes: Byte address of a register is four times its index
package sync_output_pkg;

    localparam int NUM_OUT = 8;
    localparam int REG_W = 8;
    localparam int ADDR_W = 12;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;

    // Output order: a0, a1, a2, b0, b1, c0, c1, d
    localparam logic [7:0] SEL_DELAY_IDX [NUM_OUT] = '{
        8'h28, 8'h29, 8'h2a, 8'h38, 8'h39, 8'h48, 8'h49, 8'h58
    };
    localparam logic [7:0] STATE_IDX [NUM_OUT] = '{
        8'h2c, 8'h2d, 8'h2e, 8'h3c, 8'h3d, 8'h4c, 8'h4d, 8'h5c
    };
    localparam logic [7:0] CLK_CTRL_IDX [NUM_OUT] = '{
        8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97
    };
    localparam logic [7:0] ENABLE_IDX = 8'h76;

    // Source select and delay register fields
    localparam int SRC_BIT = 4;
    localparam int DELAY_MSB = 3;
    localparam int DELAY_LSB = 1;
    localparam logic [REG_W-1:0] SEL_DELAY_MASK = 8'h1e;
    localparam logic [REG_W-1:0] SEL_DELAY_RESET = 8'h10;

    // Output state register fields
    localparam int PD_BIT = 7;
    localparam int BIAS_BIT = 5;
    localparam int FMT_BIT = 4;
    localparam int AMP_MSB = 3;
    localparam int AMP_LSB = 2;
    localparam logic [REG_W-1:0] STATE_MASK = 8'hbc;
    localparam logic [REG_W-1:0] STATE_RESET = 8'h00;

    // Clock output control register fields
    localparam int CLK_FMT_BIT = 0;
    localparam int CLK_EN_BIT = 1;
    localparam int CLK_PD_BIT = 2;
    localparam logic [REG_W-1:0] CLK_CTRL_MASK = 8'h07;
    localparam logic [REG_W-1:0] CLK_CTRL_RESET = 8'h00;

    // Shared enable register: output i sits at bit ENABLE_TOP_BIT - i
    localparam int ENABLE_TOP_BIT = 7;
    localparam logic [REG_W-1:0] ENABLE_RESET = 8'h00;

endpackage

// *** sync_output_state_regs.sv ***
// Purpose: APB register bank for the sync and clock output stages
// Assumes: APB master on ref_clk; zero wait states
// Notes: Outputs ordered a0, a1, a2, b0, b1, c0, c1, d
`timescale 1ns/10ps
`default_nettype none
module sync_output_state_regs
    import sync_output_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sync output controls
    output logic [NUM_OUT-1:0] sync_source_select,
    output logic [3*NUM_OUT-1:0] sync_phase_delay,
    output logic [NUM_OUT-1:0] sync_power_down,
    output logic [NUM_OUT-1:0] sync_bias_control,
    output logic [NUM_OUT-1:0] sync_format,
    output logic [2*NUM_OUT-1:0] sync_amplitude,
    output logic [NUM_OUT-1:0] sync_output_enable,
    // Clock output controls
    output logic [NUM_OUT-1:0] clock_out_format,
    output logic [NUM_OUT-1:0] clock_out_enable,
    output logic [NUM_OUT-1:0] clock_out_power_down,
    // Gate for the clock output stages
    input wire logic [NUM_OUT-1:0] clock_in,
    output logic [NUM_OUT-1:0] clock_output
);

    wire logic [7:0] reg_idx;
    wire logic addr_ok;
    wire logic access;
    wire logic setup;
    wire logic wr_en;
    wire logic hit_enable;
    wire logic mapped;
    wire logic [NUM_OUT-1:0] hit_sd;
    wire logic [NUM_OUT-1:0] hit_st;
    wire logic [NUM_OUT-1:0] hit_ck;
    wire logic [REG_W-1:0] rd_sd [NUM_OUT];
    wire logic [REG_W-1:0] rd_st [NUM_OUT];
    wire logic [REG_W-1:0] rd_ck [NUM_OUT];
    logic [REG_W-1:0] enable_bits;
    logic [REG_W-1:0] read_byte;

    // Misaligned or out-of-range addresses are treated as unmapped
    assign reg_idx = paddr[IDX_MSB:IDX_LSB];
    assign addr_ok = (paddr[IDX_LSB-1:0] == 2'h0) && (paddr[ADDR_W-1:IDX_MSB+1] == 2'h0);
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign hit_enable = addr_ok && (reg_idx == ENABLE_IDX);
    assign mapped = hit_enable || (|hit_sd) || (|hit_st) || (|hit_ck);
    // Data sits in lane 0, so only that strobe lets a write through
    assign wr_en = access && pwrite && pstrb[0] && mapped;

    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    generate
        for (genvar i = 0; i < NUM_OUT; i++)
        begin : g_slot
            reg_slot_if slot_bus ();

            assign hit_sd[i] = addr_ok && (reg_idx == SEL_DELAY_IDX[i]);
            assign hit_st[i] = addr_ok && (reg_idx == STATE_IDX[i]);
            assign hit_ck[i] = addr_ok && (reg_idx == CLK_CTRL_IDX[i]);
            assign slot_bus.wr_sel_delay = wr_en && hit_sd[i];
            assign slot_bus.wr_state = wr_en && hit_st[i];
            assign slot_bus.wr_clk_ctrl = wr_en && hit_ck[i];
            assign slot_bus.wdata = pwdata[REG_W-1:0];

            output_slot u_slot (
                .ref_clk(ref_clk),
                .arst_n(arst_n),
                .bus(slot_bus.slot)
            );

            assign rd_sd[i] = slot_bus.sel_delay;
            assign rd_st[i] = slot_bus.state;
            assign rd_ck[i] = slot_bus.clk_ctrl;

            assign sync_source_select[i] = rd_sd[i][SRC_BIT];
            assign sync_phase_delay[3*i +: 3] = rd_sd[i][DELAY_MSB:DELAY_LSB];
            assign sync_power_down[i] = rd_st[i][PD_BIT];
            assign sync_bias_control[i] = rd_st[i][BIAS_BIT];
            assign sync_format[i] = rd_st[i][FMT_BIT];
            assign sync_amplitude[2*i +: 2] = rd_st[i][AMP_MSB:AMP_LSB];
            assign sync_output_enable[i] = enable_bits[ENABLE_TOP_BIT - i];

            assign clock_out_format[i] = rd_ck[i][CLK_FMT_BIT];
            assign clock_out_enable[i] = rd_ck[i][CLK_EN_BIT];
            assign clock_out_power_down[i] = rd_ck[i][CLK_PD_BIT];
            // Disabled or powered-down stage sits at static low
            assign clock_output[i] = clock_in[i] && clock_out_enable[i]
                && !clock_out_power_down[i];
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            enable_bits <= ENABLE_RESET;
        else if (wr_en && hit_enable)
            enable_bits <= pwdata[REG_W-1:0];
    end

    // Read select; unmapped indices read as zero
    always_comb
    begin
        read_byte = hit_enable ? enable_bits : '0;
        for (int i = 0; i < NUM_OUT; i++)
        begin
            read_byte = read_byte
                | ({REG_W{hit_sd[i]}} & rd_sd[i])
                | ({REG_W{hit_st[i]}} & rd_st[i])
                | ({REG_W{hit_ck[i]}} & rd_ck[i]);
        end
    end

    // Captured in the setup cycle so the zero-wait access sees a flop
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            prdata <= 32'h0000_0000;
        else if (setup)
            prdata <= {24'h00_0000, read_byte};
    end

endmodule
`default_nettype wire

// *** sync_output_state_regs_properties.sv ***
// Purpose: Port-level checks for the output register bank
// Assumes: One clock domain
// Notes: Bound to every instance of the bank
`timescale 1ns/10ps
`default_nettype none
module sync_output_checker
    import sync_output_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // Controls
    input wire logic [NUM_OUT-1:0] sync_source_select,
    input wire logic [NUM_OUT-1:0] clock_out_enable,
    input wire logic [NUM_OUT-1:0] clock_out_power_down,
    input wire logic [NUM_OUT-1:0] clock_in,
    input wire logic [NUM_OUT-1:0] clock_output
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence idle_cycle;
        !(psel && penable && pwrite);
    endsequence
    gate_and_a: assert property (clock_output == (clock_in & clock_out_enable & ~clock_out_power_down))
        else $error("clock gate mismatch");
    src_idle_a: assert property (idle_cycle |=> $stable(sync_source_select))
        else $error("source select moved without write");
    en_idle_a: assert property (idle_cycle |=> $stable(clock_out_enable))
        else $error("clock enable moved without write");
    src_reset_a: assert property ($rose(arst_n) |-> sync_source_select == 8'hff)
        else $error("source select reset wrong");
    clk_reset_a: assert property ($rose(arst_n) |-> (clock_out_enable | clock_out_power_down) == 8'h00)
        else $error("clock control reset wrong");
    rd_top_a: assert property (prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    ready_a: assert property (psel && penable |-> pready)
        else $error("access not completed");
    pd_low_a: assert property (clock_out_power_down[7] [*2] |-> !clock_output[7])
        else $error("powered down output toggles");
endmodule
bind sync_output_state_regs sync_output_checker chk_i (.ref_clk, .arst_n, .psel, .penable, .pwrite,
    .prdata, .pready, .sync_source_select, .clock_out_enable, .clock_out_power_down, .clock_in,
    .clock_output);
`default_nettype wire

// *** sync_output_state_regs_tb_top.sv ***
// Purpose: Register and output checks of the bank over APB
// Assumes: Zero-wait slave, byte address is four times the index
// Notes: pstrb held at 4'hf
`timescale 1ns/10ps
`default_nettype none
module sync_output_state_regs_tb_top;
    import sync_output_pkg::*;
    logic ref_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [7:0] src, pd, bias, fmt, oen, cfmt, cen, cpd, cin, cout;
    logic [23:0] dly, e_dly;
    logic [15:0] amp;
    int miscompares = 0, cmp_count = 0;
    initial forever #20 ref_clk = ~ref_clk;
    channel_clock_src src_model (.ref_clk(ref_clk), .clock_in(cin));
    sync_output_state_regs dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_source_select(src),
        .sync_phase_delay(dly), .sync_power_down(pd), .sync_bias_control(bias),
        .sync_format(fmt), .sync_amplitude(amp), .sync_output_enable(oen),
        .clock_out_format(cfmt), .clock_out_enable(cen), .clock_out_power_down(cpd),
        .clock_in(cin), .clock_output(cout));
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Full APB transfer; released one edge before the next setup
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge ref_clk);
        penable <= 1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            miscompares++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge ref_clk);
    endtask
    initial
    begin
        repeat (20) @(posedge ref_clk);
        arst_n <= 1;
        @(posedge ref_clk);
        chk(src, 8'hff);
        chk(cen | cout, 8'h00);
        for (int i = 0; i < NUM_OUT; i++)
        begin
            apb(0, SEL_DELAY_IDX[i], 0);
            chk(rd, 32'h10);
            apb(0, STATE_IDX[i], 0);
            chk(rd, 32'h0);
            apb(0, CLK_CTRL_IDX[i], 0);
            chk(rd, 32'h0);
            apb(1, SEL_DELAY_IDX[i], {4'he, i[2:0], 1'b1});
            apb(0, SEL_DELAY_IDX[i], 0);
            chk(rd, {28'h0, i[2:0], 1'b0});
            apb(1, STATE_IDX[i], 8'hff);
            apb(0, STATE_IDX[i], 0);
            chk(rd, 32'hbc);
            e_dly[3*i+:3] = i[2:0];
        end
        chk({src, dly}, {8'h00, e_dly});
        chk({8'h00, pd, bias, fmt}, 32'h00ffffff);
        chk({16'h0000, amp}, 32'h0000ffff);
        $display("test sync fields done");
        apb(1, ENABLE_IDX, 8'h80);
        chk(oen, 8'h01);
        apb(1, ENABLE_IDX, 8'h01);
        chk(oen, 8'h80);
        $display("test enable bits done");
        for (int i = 0; i < NUM_OUT; i++)
            apb(1, CLK_CTRL_IDX[i], 8'h03);
        // Gated clock looked at mid-cycle, where the channel clock has settled
        @(negedge ref_clk);
        chk({8'h00, cfmt, cen, cout}, {16'h00ff, 8'hff, cin});
        @(posedge ref_clk);
        for (int i = 0; i < NUM_OUT; i++)
            apb(1, CLK_CTRL_IDX[i], 8'h07);
        @(negedge ref_clk);
        chk({16'h0000, cpd, cout}, 32'h0000ff00);
        @(posedge ref_clk);
        $display("test clock outputs done");
        apb(0, 8'h00, 0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1, 8'h01, 8'hff);
        chk({31'h0, err}, 32'h1);
        $display("test unmapped done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
